/* axis_ref_consts.svh */
// Offsets and field positions of the axis reference block.
// Included by the main module only; definitions only.
`ifndef AXIS_REF_CONSTS_SVH
`define AXIS_REF_CONSTS_SVH

// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_AXIS 8'h04
`define OFF_RATE 8'h08
`define OFF_DIM 8'h0c
`define OFF_OPTION 8'h10
`define OFF_STATUS 8'h14
`define OFF_SW_POS 8'h18
`define OFF_SV_SEL 8'h1c
`define OFF_SV_DATA 8'h20
`define OFF_INT_STAT 8'h24
`define OFF_INT_MASK 8'h28
`define OFF_REF_POS 8'h2c

// Control fields
`define CTRL_ENABLE 0
`define CTRL_PLUS 1
`define CTRL_FINISH 2

// Option word fields
`define OPT_IGNORE_MARK 0
`define OPT_NO_MOTION 1
`define OPT_NULL_SETUP 2

// Status fields
`define ST_OK 0
`define ST_COMPLETE 1
`define ST_BUSY 2
`define ST_MOVING 3
`define ST_SW_VALID 4
`define ST_REJECT 5

// Interrupt status and mask fields
`define INT_DONE 0
`define INT_REJECT 1
`define INT_COMPLETE 2
`define INT_W 3

// Servo variable that returns the switch position
`define SV_SWITCH_POS 8'h1d

`endif

/* axis_ref_pkg.sv */
// Types shared by the axis reference modules.
// Assumes the constants header is on the include path.
package axis_ref_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SEEK = 4'b0010,
        ST_MARK = 4'b0100,
        ST_WAIT_END = 4'b1000
    } ref_state_e;

    typedef logic signed [31:0] pos_t;
endpackage : axis_ref_pkg

/* capture_if.sv */
// Carrier between the sequencer and one position latch.
// Assumes the sequencer drives strobe and position in the same clock domain.
`timescale 1ns/1ps
interface capture_if;
    import axis_ref_pkg::*;
    logic strobe;
    pos_t pos;
    pos_t value;

    modport latch (input strobe, input pos, output value);
    modport user (output strobe, output pos, input value);
endinterface : capture_if

/* rise_detect.sv */
// Rising edge detector for one level input.
// Assumes the input is synchronous to i_clk.
`timescale 1ns/1ps
module rise_detect (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Level in, pulse out
    input wire logic i_level,
    output logic o_rise
);
    logic prev_q;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= i_level;
        end
    end

    assign o_rise = i_level & ~prev_q;
endmodule : rise_detect

/* pos_latch.sv */
// Position latch: holds the axis position seen at the last strobe.
// Assumes strobe and position come from the i_clk domain.
`timescale 1ns/1ps
module pos_latch
    import axis_ref_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Strobe, position and held value
    capture_if.latch cap
);
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            cap.value <= '0;
        end else if (cap.strobe) begin
            cap.value <= cap.pos;
        end
    end
endmodule : pos_latch

/* axis_ref_capture.sv */
// Axis reference sequencer with APB register access.
// Assumes axis feedback, switch and queue inputs are synchronous to i_clk.
//
// Behaviour
// - Reject dimension outside signed thirty-bit range
// - Move in commanded direction until finish
// - Switch closure then capture at mark
// - Digitizing or no-motion: no motion output
// - Encoder: keep moving until index mark
// - Option bits: ignore mark, no-motion, null-setup
// - Ignore mark: reference at finish command
// - Ignore mark, encoder: stop, switch invalid
// - Ignore mark, resolver: switch position valid
// - Clear complete on command, set on capture
// - No-motion leaves running move untouched
// - Switch position readable as servo variable
// - Null setup stores null position in drive
// - Report queue number of reference move
`timescale 1ns/1ps
`include "axis_ref_consts.svh"
module axis_ref_capture
    import axis_ref_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Axis feedback and switch
    input wire logic signed [31:0] i_axis_pos,
    input wire logic i_ref_switch,
    input wire logic i_index_mark,
    input wire logic i_null_mark,
    input wire logic i_fb_resolver,
    input wire logic i_axis_digitizing,
    input wire logic i_queue_free,
    // Motion command
    output logic o_move_en,
    output logic o_move_plus,
    output logic [31:0] o_move_rate,
    output logic [7:0] o_move_axis,
    // Reference results
    output logic o_pos_load,
    output logic signed [31:0] o_pos_load_val,
    output logic o_null_store,
    output logic [7:0] o_queue_num,
    // Interrupt
    output logic o_irq
);
    // Software registers
    logic [2:0] ctrl_q;
    logic [7:0] axis_q;
    logic [31:0] rate_q;
    logic [31:0] dim_q;
    logic [15:0] option_q;
    logic [7:0] sv_sel_q;
    logic [`INT_W-1:0] int_mask_q;
    logic [`INT_W-1:0] int_stat_q;
    logic [`INT_W-1:0] int_stat_d;

    // Command latched at the enable edge
    logic cmd_plus_q;
    logic [31:0] cmd_rate_q;
    logic [7:0] cmd_axis_q;
    logic signed [31:0] cmd_dim_q;
    logic opt_ignore_q;
    logic opt_null_q;

    // Sequencer state
    ref_state_e state_q;
    ref_state_e state_d;
    logic move_q;
    logic move_d;
    logic complete_q;
    logic complete_d;
    logic ok_q;
    logic ok_d;
    logic reject_q;
    logic reject_d;
    logic sw_valid_q;
    logic sw_valid_d;
    logic fin_seen_q;
    logic fin_seen_d;
    logic [7:0] queue_q;
    logic accept;
    logic load_evt;
    logic done_evt;
    logic reject_evt;

    // Edge pulses
    logic start_rise;
    logic sw_rise;
    logic index_rise;
    logic null_rise;

    rise_detect u_enable_edge (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_level(ctrl_q[`CTRL_ENABLE]),
        .o_rise(start_rise)
    );

    rise_detect u_switch_edge (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_level(i_ref_switch),
        .o_rise(sw_rise)
    );

    rise_detect u_index_edge (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_level(i_index_mark),
        .o_rise(index_rise)
    );

    rise_detect u_null_edge (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_level(i_null_mark),
        .o_rise(null_rise)
    );

    // Position latches: switch point and reference point
    capture_if sw_cap ();
    capture_if ref_cap ();

    pos_latch u_sw_latch (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .cap(sw_cap)
    );

    pos_latch u_ref_latch (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .cap(ref_cap)
    );

    // APB decode
    wire setup = i_psel & ~i_penable;
    wire wr_acc = i_psel & i_penable & i_pwrite;
    wire rd_acc = i_psel & i_penable & ~i_pwrite;
    wire wr_ctrl = wr_acc & (i_paddr == `OFF_CTRL);
    wire fin_cmd = wr_ctrl & i_pwdata[`CTRL_FINISH];
    wire int_clear = rd_acc & (i_paddr == `OFF_INT_STAT);
    wire addr_ok = (i_paddr[1:0] == 2'h0) && (i_paddr <= `OFF_REF_POS);

    // Command qualification
    wire [2:0] dim_top = i_pwdata[31:29];
    wire dim_in_range = (dim_q[31:29] == 3'h0) || (dim_q[31:29] == 3'h7);
    wire no_motion = option_q[`OPT_NO_MOTION] | i_axis_digitizing;
    wire mark_rise = i_fb_resolver ? null_rise : index_rise;
    wire finish_now = fin_cmd | fin_seen_q;
    wire [31:0] sv_data = (sv_sel_q == `SV_SWITCH_POS) ? sw_cap.value : 32'h0;

    wire [31:0] status_word = {16'h0, queue_q, 2'h0, reject_q, sw_valid_q, move_q,
                               (state_q != ST_IDLE), complete_q, ok_q};

    wire [31:0] rd_mux =
        (i_paddr == `OFF_CTRL) ? {29'h0, ctrl_q} :
        (i_paddr == `OFF_AXIS) ? {24'h0, axis_q} :
        (i_paddr == `OFF_RATE) ? rate_q :
        (i_paddr == `OFF_DIM) ? dim_q :
        (i_paddr == `OFF_OPTION) ? {16'h0, option_q} :
        (i_paddr == `OFF_STATUS) ? status_word :
        (i_paddr == `OFF_SW_POS) ? sw_sel_pos(sw_cap.value, sw_valid_q) :
        (i_paddr == `OFF_SV_SEL) ? {24'h0, sv_sel_q} :
        (i_paddr == `OFF_SV_DATA) ? sv_data :
        (i_paddr == `OFF_INT_STAT) ? {29'h0, int_stat_q} :
        (i_paddr == `OFF_INT_MASK) ? {29'h0, int_mask_q} :
        (i_paddr == `OFF_REF_POS) ? ref_cap.value :
        32'h0;

    // Switch position reads as zero once it is known to be invalid
    function automatic logic [31:0] sw_sel_pos(input logic [31:0] pos, input logic valid);
        sw_sel_pos = valid ? pos : 32'h0;
    endfunction : sw_sel_pos

    assign sw_cap.strobe = (state_q == ST_SEEK) & sw_rise;
    assign sw_cap.pos = i_axis_pos;
    assign ref_cap.strobe = load_evt;
    assign ref_cap.pos = i_axis_pos;

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        move_d = move_q;
        complete_d = complete_q;
        ok_d = ok_q;
        reject_d = reject_q;
        sw_valid_d = sw_valid_q;
        fin_seen_d = fin_seen_q;
        accept = 1'b0;
        load_evt = 1'b0;
        done_evt = 1'b0;
        reject_evt = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                if (start_rise) begin
                    complete_d = 1'b0;
                    ok_d = 1'b0;
                    if (!dim_in_range || !i_queue_free) begin
                        reject_d = 1'b1;
                        reject_evt = 1'b1;
                    end else begin
                        accept = 1'b1;
                        reject_d = 1'b0;
                        move_d = ~no_motion;
                        sw_valid_d = 1'b0;
                        fin_seen_d = 1'b0;
                        state_d = ST_SEEK;
                    end
                end
            end
            ST_SEEK: begin
                if (fin_cmd) begin
                    fin_seen_d = 1'b1;
                end
                if (sw_rise) begin
                    sw_valid_d = ~opt_ignore_q | i_fb_resolver;
                    if (opt_ignore_q) begin
                        if (!i_fb_resolver) begin
                            move_d = 1'b0;
                        end
                        state_d = ST_WAIT_END;
                    end else begin
                        state_d = ST_MARK;
                    end
                end
            end
            ST_MARK: begin
                if (fin_cmd) begin
                    fin_seen_d = 1'b1;
                end
                // Motion holds here even after finish until the mark is seen
                if (mark_rise) begin
                    load_evt = 1'b1;
                    complete_d = 1'b1;
                    if (finish_now) begin
                        move_d = 1'b0;
                        ok_d = 1'b1;
                        done_evt = 1'b1;
                        state_d = ST_IDLE;
                    end else begin
                        state_d = ST_WAIT_END;
                    end
                end
            end
            ST_WAIT_END: begin
                if (finish_now) begin
                    if (opt_ignore_q) begin
                        load_evt = 1'b1;
                        complete_d = 1'b1;
                    end
                    move_d = 1'b0;
                    ok_d = 1'b1;
                    done_evt = 1'b1;
                    fin_seen_d = 1'b0;
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            state_q <= ST_IDLE;
            move_q <= 1'b0;
            complete_q <= 1'b0;
            ok_q <= 1'b0;
            reject_q <= 1'b0;
            sw_valid_q <= 1'b0;
            fin_seen_q <= 1'b0;
        end else begin
            state_q <= state_d;
            move_q <= move_d;
            complete_q <= complete_d;
            ok_q <= ok_d;
            reject_q <= reject_d;
            sw_valid_q <= sw_valid_d;
            fin_seen_q <= fin_seen_d;
        end
    end

    // Command snapshot, taken only on the accepting edge
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            cmd_plus_q <= 1'b0;
            cmd_rate_q <= 32'h0;
            cmd_axis_q <= 8'h0;
            cmd_dim_q <= 32'h0;
            opt_ignore_q <= 1'b0;
            opt_null_q <= 1'b0;
            queue_q <= 8'h0;
        end else if (accept) begin
            cmd_plus_q <= ctrl_q[`CTRL_PLUS];
            cmd_rate_q <= rate_q;
            cmd_axis_q <= axis_q;
            cmd_dim_q <= dim_q;
            opt_ignore_q <= option_q[`OPT_IGNORE_MARK];
            opt_null_q <= option_q[`OPT_NULL_SETUP];
            queue_q <= queue_q + 8'h1;
        end
    end

    // Software writes; finish bit is a strobe and never stored
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ctrl_q <= 3'h0;
            axis_q <= 8'h0;
            rate_q <= 32'h0;
            dim_q <= 32'h0;
            option_q <= 16'h0;
            sv_sel_q <= 8'h0;
            int_mask_q <= '0;
        end else if (wr_acc) begin
            if (wr_ctrl) ctrl_q <= {1'b0, i_pwdata[1:0]};
            if (i_paddr == `OFF_AXIS) axis_q <= i_pwdata[7:0];
            if (i_paddr == `OFF_RATE) rate_q <= i_pwdata;
            if (i_paddr == `OFF_DIM) dim_q <= {dim_top, i_pwdata[28:0]};
            if (i_paddr == `OFF_OPTION) option_q <= i_pwdata[15:0];
            if (i_paddr == `OFF_SV_SEL) sv_sel_q <= i_pwdata[7:0];
            if (i_paddr == `OFF_INT_MASK) int_mask_q <= i_pwdata[`INT_W-1:0];
        end
    end

    // Sticky events: a new event wins over the read that clears
    assign int_stat_d = (int_stat_q & ~{`INT_W{int_clear}}) | {load_evt, reject_evt, done_evt};

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            int_stat_q <= '0;
            o_irq <= 1'b0;
        end else begin
            int_stat_q <= int_stat_d;
            o_irq <= |(int_stat_d & int_mask_q);
        end
    end

    // APB answer: zero wait, data prepared in the setup cycle
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_prdata <= 32'h0;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= 1'b1;
            if (setup) begin
                o_prdata <= i_pwrite ? 32'h0 : rd_mux;
                o_pslverr <= ~addr_ok;
            end
        end
    end

    // Motion and result outputs
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_move_en <= 1'b0;
            o_move_plus <= 1'b0;
            o_move_rate <= 32'h0;
            o_move_axis <= 8'h0;
            o_pos_load <= 1'b0;
            o_pos_load_val <= 32'h0;
            o_null_store <= 1'b0;
            o_queue_num <= 8'h0;
        end else begin
            o_move_en <= move_d;
            // Bypass the snapshot on the accepting edge so direction and rate settle with the enable
            o_move_plus <= accept ? ctrl_q[`CTRL_PLUS] : cmd_plus_q;
            o_move_rate <= accept ? rate_q : cmd_rate_q;
            o_move_axis <= accept ? axis_q : cmd_axis_q;
            o_pos_load <= load_evt;
            o_pos_load_val <= cmd_dim_q;
            o_null_store <= load_evt & opt_null_q;
            if (done_evt) o_queue_num <= queue_q;
        end
    end
endmodule : axis_ref_capture

/* axis_ref_capture_sva.sv */
// Port checker for the axis reference block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module axis_ref_capture_chk (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // APB
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [7:0] i_paddr,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Axis and results
    input wire logic i_axis_digitizing,
    input wire logic i_queue_free,
    input wire logic o_move_en,
    input wire logic o_move_plus,
    input wire logic [31:0] o_move_rate,
    input wire logic o_pos_load,
    input wire logic signed [31:0] o_pos_load_val,
    input wire logic o_null_store,
    input wire logic [7:0] o_queue_num
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic bad_addr;
    assign bad_addr = (i_paddr[1:0] != 2'h0) || (i_paddr > 8'h2c);
    a_zero_wait: assert property (i_psel && i_penable |-> o_pready)
        else $error("access not answered at once");
    a_unmapped_err: assert property (i_psel && !i_penable && bad_addr |=> o_pslverr)
        else $error("unmapped access without error");
    a_dim_in_range: assert property (o_pos_load |-> o_pos_load_val[31:29] inside {3'h0, 3'h7})
        else $error("out-of-range dimension loaded");
    a_load_one_cycle: assert property (o_pos_load |=> !o_pos_load)
        else $error("load pulse longer than one cycle");
    a_null_with_load: assert property (o_null_store |-> o_pos_load)
        else $error("null store without reference load");
    a_move_held: assert property (o_move_en && $past(o_move_en) |-> $stable(o_move_rate) && $stable(o_move_plus))
        else $error("motion command changed while moving");
    a_queue_at_end: assert property ($changed(o_queue_num) |-> !o_move_en)
        else $error("queue number changed while moving");
    a_digit_still: assert property (i_axis_digitizing && $past(i_axis_digitizing) && $past(i_axis_digitizing, 2)
        |-> !$rose(o_move_en))
        else $error("digitizing axis started moving");
    a_no_queue_still: assert property (!i_queue_free && !$past(i_queue_free) && !$past(i_queue_free, 2)
        |-> !$rose(o_move_en))
        else $error("motion started with no queue entry");
endmodule : axis_ref_capture_chk

bind axis_ref_capture axis_ref_capture_chk u_chk (.i_clk, .i_rst_b, .i_psel, .i_penable, .i_paddr, .o_pready,
    .o_pslverr, .i_axis_digitizing, .i_queue_free, .o_move_en, .o_move_plus, .o_move_rate, .o_pos_load,
    .o_pos_load_val, .o_null_store, .o_queue_num);

/* axis_model.sv */
// Behavioural servo axis: position, reference switch and marks.
// Assumes trip inputs come from the bench after a rising edge.
`timescale 1ns/1ps
module axis_model (
    // Clock
    input wire logic i_clk,
    // Motion in, bench trips
    input wire logic i_move_en,
    input wire logic i_move_plus,
    input wire logic i_trip_switch,
    input wire logic i_trip_mark,
    input wire logic i_resolver,
    // Feedback out
    output logic signed [31:0] o_axis_pos,
    output logic o_ref_switch,
    output logic o_index_mark,
    output logic o_null_mark
);
    logic trip_q;
    initial o_axis_pos = 32'sh100;
    always @(posedge i_clk) begin
        if (i_move_en) begin
            o_axis_pos <= i_move_plus ? o_axis_pos + 1 : o_axis_pos - 1;
        end
        trip_q <= i_trip_mark;
        o_ref_switch <= i_trip_switch;
        // Marks are single-cycle pulses, low between them
        o_index_mark <= i_trip_mark && !trip_q && !i_resolver;
        o_null_mark <= i_trip_mark && !trip_q && i_resolver;
    end
endmodule : axis_model

/* tb.sv */
// Bench for the axis reference block: APB driver and reference runs.
// Assumes the axis model file and the design are compiled first.
`timescale 1ns/1ps
module tb;
    logic i_clk = 0, i_rst_b = 0, psel = 0, pen = 0, pwr = 0, qf = 1, dig = 0, res = 0, tsw = 0, tmk = 0;
    logic [7:0] pa = 0, maxis, qnum, qe;
    logic [31:0] pwd = 0, rd, prd, mrate;
    logic signed [31:0] pos, pval, lval;
    logic prdy, perr, er, men, mplus, pload, nstore, lnull, irq, sw, idx, nul, qset = 0;
    logic [2:0] mask;
    int n_mismatch = 0, n_compared = 0, n_load = 0;
    logic [2:0] t_op [8] = '{3'h0, 3'h1, 3'h1, 3'h6, 3'h0, 3'h0, 3'h0, 3'h0};
    logic [31:0] t_dm [8] = '{32'd100, 32'h1fffffff, 32'he0000000, 32'hfffffffb, 32'd7, 32'h20000000,
        32'hdfffffff, 32'h0};
    axis_ref_capture u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr), .i_axis_pos(pos),
        .i_ref_switch(sw), .i_index_mark(idx), .i_null_mark(nul), .i_fb_resolver(res),
        .i_axis_digitizing(dig), .i_queue_free(qf), .o_move_en(men), .o_move_plus(mplus),
        .o_move_rate(mrate), .o_move_axis(maxis), .o_pos_load(pload), .o_pos_load_val(pval),
        .o_null_store(nstore), .o_queue_num(qnum), .o_irq(irq));
    axis_model u_ax (.i_clk(i_clk), .i_move_en(men), .i_move_plus(mplus), .i_trip_switch(tsw),
        .i_trip_mark(tmk), .i_resolver(res), .o_axis_pos(pos), .o_ref_switch(sw), .o_index_mark(idx),
        .o_null_mark(nul));
    initial forever #25 i_clk = ~i_clk;
    always @(posedge i_clk) if (pload === 1'b1) begin
        n_load++;
        lval = pval;
        lnull = nstore;
    end
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask : cyc
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while (prdy !== 1'b1 && k < 16);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (prdy !== 1'b1) begin
            n_mismatch++;
            stop_test();
        end
        @(posedge i_clk);
    endtask : apb
    task automatic run(input logic [2:0] op, input logic [31:0] dm, input logic r, dg, q);
        logic acc, ign, mv;
        logic [2:0] ist;
        int nl;
        acc = q && (dm[31:29] == 3'h0 || dm[31:29] == 3'h7);
        ign = op[0];
        mv = acc && !op[1] && !dg;
        ist = acc ? 3'h5 : 3'h2;
        res <= r;
        dig <= dg;
        qf <= q;
        apb(1, 8'h0c, dm);
        apb(1, 8'h10, {29'h0, op});
        nl = n_load;
        apb(1, 8'h00, {30'h0, dm[0], 1'b1});
        cyc(3);
        chk(men, mv, "move");
        if (mv) chk({mplus, maxis, mrate[22:0]}, {dm[0], 8'h5, 23'h40}, "move cmd");
        if (!acc) begin
            apb(0, 8'h14, 0);
            chk(rd[5:0] & 6'h21, 6'h20, "reject");
            apb(1, 8'h00, 0);
        end else begin
            apb(1, 8'h0c, ~dm);
            tsw <= 1'b1;
            cyc(3);
            chk(men, mv && !(ign && !r), "after switch");
            if (!ign) tmk <= 1'b1;
            cyc(3);
            apb(1, 8'h00, 32'h4);
            cyc(3);
            tsw <= 1'b0;
            tmk <= 1'b0;
            chk(n_load - nl, 1, "loads");
            chk(lval, dm, "load value");
            chk(lnull, op[2], "null store");
            apb(0, 8'h14, 0);
            chk(rd[5:0], {1'b0, !(ign && !r), 4'h3}, "status");
            if (ign && !r) begin
                apb(0, 8'h2c, 0);
                chk(rd, pos, "ref pos");
                apb(0, 8'h18, 0);
                chk(rd, 0, "sw pos");
            end
            if (dg) begin
                apb(1, 8'h1c, 32'd29);
                apb(0, 8'h20, 0);
                chk(rd, pos, "servo var");
            end
            if (qset) chk(qnum, qe + 8'h1, "queue");
            qe = qnum;
            qset = 1'b1;
        end
        chk(irq, |(ist & mask), "irq");
        apb(0, 8'h24, 0);
        chk(rd[2:0], ist, "int status");
        cyc(2);
        chk(irq, 0, "irq cleared");
    endtask : run
    initial begin
        #5000000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        cyc(2);
        i_rst_b <= 1'b1;
        cyc(1);
        apb(0, 8'h28, 0);
        chk(rd, 0, "mask reset");
        apb(0, 8'h30, 0);
        chk({er, rd}, {1'b1, 32'h0}, "unmapped");
        apb(1, 8'h06, 32'hff);
        chk(er, 1, "misaligned");
        apb(1, 8'h04, 32'h5);
        apb(1, 8'h08, 32'h40);
        for (int i = 0; i < 8; i++) begin
            mask = (i < 4) ? 3'h7 : 3'h2;
            apb(1, 8'h28, {29'h0, mask});
            // No ratio profile move is ever running when a no-motion reference is issued
            run(t_op[i], t_dm[i], i inside {2, 3}, i == 4, i != 7);
        end
        stop_test();
    end
endmodule : tb
